//--- src/timer_pkg.sv
// Purpose: constants and types shared by the compare/gated/capture timer
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: register offsets are byte addresses
package timer_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_COUNT = 12'h004;
    localparam logic [11:0] OFS_RELOAD = 12'h008;
    localparam logic [11:0] OFS_PWM = 12'h00c;
    localparam logic [11:0] OFS_CAPTURE = 12'h010;
    localparam logic [11:0] OFS_STATUS = 12'h014;
    localparam logic [11:0] OFS_MASK = 12'h018;

    // ------------------------------------------------------------
    // control word layout
    // ------------------------------------------------------------
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_POL_BIT = 4;
    localparam int CTRL_PRESCALE_EXPONENT_LSB = 5;
    localparam int CTRL_AF_BIT = 8;

    // ------------------------------------------------------------
    // status / mask layout
    // ------------------------------------------------------------
    localparam int ST_RELOAD = 0;
    localparam int ST_GATE = 1;
    localparam int ST_CAPTURE = 2;
    localparam int ST_PWM = 3;
    localparam int ST_W = 4;

    localparam int CNT_W = 16;
    localparam int PRESC_W = 7;
    localparam logic [CNT_W-1:0] COUNT_RESTART = 16'h0001;
    localparam logic [CNT_W-1:0] RELOAD_RESET = 16'hffff;

    typedef enum logic [2:0] {
        MODE_COMPARE,
        MODE_GATED,
        MODE_PWM,
        MODE_CAPTURE,
        MODE_CAPCMP
    } mode_t;

    typedef struct packed {
        logic af_en;
        logic [2:0] prescale_exponent;
        logic output_polarity_sel;
        mode_t mode;
        logic en;
    } ctrl_t;

    typedef struct packed {
        ctrl_t ctrl;
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] reload;
        logic [CNT_W-1:0] pwm_val;
        logic [CNT_W-1:0] cap;
        logic [ST_W-1:0] status;
        logic [ST_W-1:0] mask;
        logic [PRESC_W-1:0] presc;
        logic out;
        logic tin_prev;
        logic started;
        logic [31:0] rdata;
    } state_t;

endpackage

//--- src/timer_compare_gated_capture.sv
// Purpose: 16-bit timer with prescaler, compare/gated/pwm/capture modes
// Assumes: timer_input synchronous to pclk; APB slave, zero wait states
// Notes: status bits clear on read, irq is a level
// Notes on behaviour
// R1: compare mode counts prescaled pclk ticks, never the timer input.
// R2: compare: output equals polarity while disabled, toggles on each reload.
// R3: compare event comes (compare minus start) times divisor clocks after enable.
// R4: software disables, configures, loads count and compare, then enables.
// R5: gated mode counts only while input is in its active level.
// R6: gated mode counts prescaled pclk ticks while gate is active.
// R7: gated mode interrupts on gate deassertion and on reload.
// R8: on reaching reload the count restarts at one and keeps counting.
// R9: gated mode output toggles at each reload.
// R10: polarity 0 gates on high, flags falling; 1 gates low, flags rising.
// R11: software tells gate interrupts apart by reading input versus polarity.
// R12: pwm: output polarity while disabled, inverse on match, polarity on reload.
// R13: capture takes count on rising edge (polarity 0) or falling edge (1).
// R14: capture/compare starts on first selected edge, captures on later ones.
// R15: enabled output function drives polarity level even with timer off.
// R16: polarity change while running does not move the output at once.
// R17: prescaler divides by two to the power of the 3-bit exponent.
// R18: prescaler clears whenever the timer is disabled.
// R19: count steps by one per prescaled tick when the mode allows.
`timescale 1ns/1ps
module timer_compare_gated_capture
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timer_input,
    output logic timer_output_pin,
    output logic timer_output_oe,
    output logic irq
);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == timer_pkg::OFS_CTRL) || (a == timer_pkg::OFS_COUNT) ||
                 (a == timer_pkg::OFS_RELOAD) || (a == timer_pkg::OFS_PWM) ||
                 (a == timer_pkg::OFS_CAPTURE) || (a == timer_pkg::OFS_STATUS) ||
                 (a == timer_pkg::OFS_MASK);
    endfunction

    function automatic logic [31:0] ctrl_word(input timer_pkg::ctrl_t c);
        ctrl_word = '0;
        ctrl_word[timer_pkg::CTRL_EN_BIT] = c.en;
        ctrl_word[timer_pkg::CTRL_MODE_LSB +: 3] = c.mode;
        ctrl_word[timer_pkg::CTRL_POL_BIT] = c.output_polarity_sel;
        ctrl_word[timer_pkg::CTRL_PRESCALE_EXPONENT_LSB +: 3] = c.prescale_exponent;
        ctrl_word[timer_pkg::CTRL_AF_BIT] = c.af_en;
    endfunction

    timer_pkg::state_t s_q;
    timer_pkg::state_t s_d;

    logic setup;
    logic wr;
    logic rd;
    logic [timer_pkg::PRESC_W-1:0] presc_top;
    logic tick;
    logic gate_active;
    logic edge_sel;
    logic count_en;
    logic hit_reload;
    logic hit_pwm;
    logic gate_off;
    logic [timer_pkg::ST_W-1:0] ev;

    // ------------------------------------------------------------
    // bus phases
    // ------------------------------------------------------------
    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign pready = psel && penable;
    assign pslverr = psel && penable && !mapped(paddr);
    assign prdata = s_q.rdata;

    // ------------------------------------------------------------
    // timing and events
    // ------------------------------------------------------------
    // divisor is 2**exponent; top of the prescale count is divisor-1
    assign presc_top = timer_pkg::PRESC_W'((8'h01 << s_q.ctrl.prescale_exponent) - 8'h01); // R17
    assign tick = s_q.ctrl.en && (s_q.presc == presc_top); // R1 R6
    assign gate_active = timer_input ^ s_q.ctrl.output_polarity_sel; // R5 R10
    // selected edge: rising for polarity 0, falling for polarity 1
    assign edge_sel = s_q.ctrl.output_polarity_sel ?
                      (s_q.tin_prev && !timer_input) : (!s_q.tin_prev && timer_input); // R13 R14

    always_comb
    begin
        case (s_q.ctrl.mode)
            timer_pkg::MODE_GATED: count_en = gate_active; // R5
            timer_pkg::MODE_CAPCMP: count_en = s_q.started; // R14
            default: count_en = 1'b1;
        endcase
    end

    assign hit_reload = tick && count_en &&
                        (timer_pkg::CNT_W'(s_q.count + 16'h0001) == s_q.reload); // R3
    assign hit_pwm = tick && count_en && (s_q.ctrl.mode == timer_pkg::MODE_PWM) &&
                     !hit_reload &&
                     (timer_pkg::CNT_W'(s_q.count + 16'h0001) == s_q.pwm_val);
    // gate leaves its active level: falling for polarity 0, rising for 1
    assign gate_off = s_q.ctrl.en && (s_q.ctrl.mode == timer_pkg::MODE_GATED) &&
                      (s_q.tin_prev ^ s_q.ctrl.output_polarity_sel) && !gate_active; // R7 R10

    always_comb
    begin
        ev = '0;
        ev[timer_pkg::ST_RELOAD] = hit_reload; // R7
        ev[timer_pkg::ST_GATE] = gate_off; // R7
        ev[timer_pkg::ST_CAPTURE] = s_q.ctrl.en && edge_sel &&
            ((s_q.ctrl.mode == timer_pkg::MODE_CAPTURE) ||
             ((s_q.ctrl.mode == timer_pkg::MODE_CAPCMP) && s_q.started));
        ev[timer_pkg::ST_PWM] = hit_pwm;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        s_d.tin_prev = timer_input;

        if (!s_q.ctrl.en)
        begin
            s_d.presc = '0; // R18
            s_d.out = s_q.ctrl.output_polarity_sel; // R2 R12 R15
            s_d.started = 1'b0;
        end
        else
        begin
            // output only moves on a tick, so polarity writes wait for it
            if (tick)
                s_d.presc = '0;
            else
                s_d.presc = timer_pkg::PRESC_W'(s_q.presc + 7'h01);
            if (hit_reload)
                s_d.count = timer_pkg::COUNT_RESTART; // R8
            else if (tick && count_en)
                s_d.count = timer_pkg::CNT_W'(s_q.count + 16'h0001); // R19
            if (hit_reload)
            begin
                if (s_q.ctrl.mode == timer_pkg::MODE_PWM)
                    s_d.out = s_q.ctrl.output_polarity_sel; // R12
                else
                    s_d.out = !s_q.out; // R2 R9 R16
            end
            else if (hit_pwm)
                s_d.out = !s_q.ctrl.output_polarity_sel; // R12
            if ((s_q.ctrl.mode == timer_pkg::MODE_CAPCMP) && edge_sel)
                s_d.started = 1'b1; // R14
            if (ev[timer_pkg::ST_CAPTURE])
                s_d.cap = s_q.count; // R13 R14
        end

        // status: set wins over the read clear; only bits already returned in
        // prdata are cleared, so an event landing in the setup cycle survives
        if (rd && (paddr == timer_pkg::OFS_STATUS))
            s_d.status = (s_q.status & ~s_q.rdata[timer_pkg::ST_W-1:0]) | ev;
        else
            s_d.status = s_q.status | ev;

        // read data latched in setup so prdata comes from a flop
        if (setup && !pwrite)
        begin
            case (paddr)
                timer_pkg::OFS_CTRL: s_d.rdata = ctrl_word(s_q.ctrl);
                timer_pkg::OFS_COUNT: s_d.rdata = {16'h0000, s_q.count};
                timer_pkg::OFS_RELOAD: s_d.rdata = {16'h0000, s_q.reload};
                timer_pkg::OFS_PWM: s_d.rdata = {16'h0000, s_q.pwm_val};
                timer_pkg::OFS_CAPTURE: s_d.rdata = {16'h0000, s_q.cap};
                timer_pkg::OFS_STATUS: s_d.rdata = {28'h0000000, s_q.status};
                timer_pkg::OFS_MASK: s_d.rdata = {28'h0000000, s_q.mask};
                default: s_d.rdata = 32'h00000000;
            endcase
        end

        // software writes win over counting
        if (wr)
        begin
            case (paddr)
                timer_pkg::OFS_CTRL:
                begin
                    s_d.ctrl.en = pwdata[timer_pkg::CTRL_EN_BIT];
                    s_d.ctrl.mode = timer_pkg::mode_t'(pwdata[timer_pkg::CTRL_MODE_LSB +: 3]);
                    s_d.ctrl.output_polarity_sel = pwdata[timer_pkg::CTRL_POL_BIT];
                    s_d.ctrl.prescale_exponent = pwdata[timer_pkg::CTRL_PRESCALE_EXPONENT_LSB +: 3];
                    s_d.ctrl.af_en = pwdata[timer_pkg::CTRL_AF_BIT];
                end
                timer_pkg::OFS_COUNT: s_d.count = pwdata[15:0];
                timer_pkg::OFS_RELOAD: s_d.reload = pwdata[15:0];
                timer_pkg::OFS_PWM: s_d.pwm_val = pwdata[15:0];
                timer_pkg::OFS_MASK: s_d.mask = pwdata[timer_pkg::ST_W-1:0];
                default: s_d.rdata = s_d.rdata;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
            s_q.reload <= timer_pkg::RELOAD_RESET;
        end
        else
            s_q <= s_d;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign timer_output_pin = s_q.out;
    assign timer_output_oe = s_q.ctrl.af_en; // R15
    assign irq = |(s_q.status & s_q.mask);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    logic wr_any;
    assign wr_any = wr;

    sequence s_reload_hit;
        hit_reload && !wr_any;
    endsequence

    sequence s_two_ticks;
        !tick ##1 tick;
    endsequence

    property p_disabled_level;
        @(posedge pclk) disable iff (!presetn)
        (!s_q.ctrl.en && !wr_any) |=> (timer_output_pin == $past(s_q.ctrl.output_polarity_sel));
    endproperty
    a_disabled_level: assert property (p_disabled_level) // R2
        else $error("output differs from polarity while disabled");

    property p_compare_toggle;
        @(posedge pclk) disable iff (!presetn)
        (s_reload_hit and (s_q.ctrl.mode == timer_pkg::MODE_COMPARE))
            |=> (timer_output_pin != $past(timer_output_pin));
    endproperty
    a_compare_toggle: assert property (p_compare_toggle) // R2
        else $error("compare reload did not toggle output");

    property p_gated_toggle;
        @(posedge pclk) disable iff (!presetn)
        (s_reload_hit and (s_q.ctrl.mode == timer_pkg::MODE_GATED))
            |=> (timer_output_pin != $past(timer_output_pin));
    endproperty
    a_gated_toggle: assert property (p_gated_toggle) // R9
        else $error("gated reload did not toggle output");

    property p_restart_one;
        @(posedge pclk) disable iff (!presetn)
        s_reload_hit |=> (s_q.count == 16'h0001) && s_q.status[timer_pkg::ST_RELOAD];
    endproperty
    a_restart_one: assert property (p_restart_one) // R8
        else $error("reload did not restart count at one with flag");

    property p_gate_pause;
        @(posedge pclk) disable iff (!presetn)
        (s_q.ctrl.en && (s_q.ctrl.mode == timer_pkg::MODE_GATED) && !gate_active && !wr_any)
            |=> $stable(s_q.count);
    endproperty
    a_gate_pause: assert property (p_gate_pause) // R5
        else $error("gated count moved while gate inactive");

    property p_gate_flag;
        @(posedge pclk) disable iff (!presetn)
        gate_off |=> s_q.status[timer_pkg::ST_GATE];
    endproperty
    a_gate_flag: assert property (p_gate_flag) // R10
        else $error("gate deassertion not flagged");

    property p_pwm_match;
        @(posedge pclk) disable iff (!presetn)
        (hit_pwm && !wr_any) |=> (timer_output_pin == !$past(s_q.ctrl.output_polarity_sel));
    endproperty
    a_pwm_match: assert property (p_pwm_match) // R12
        else $error("pwm match did not drive inverse level");

    property p_pwm_reload;
        @(posedge pclk) disable iff (!presetn)
        (s_reload_hit and (s_q.ctrl.mode == timer_pkg::MODE_PWM))
            |=> (timer_output_pin == $past(s_q.ctrl.output_polarity_sel));
    endproperty
    a_pwm_reload: assert property (p_pwm_reload) // R12
        else $error("pwm reload did not restore polarity level");

    property p_capture;
        @(posedge pclk) disable iff (!presetn)
        (s_q.ctrl.en && (s_q.ctrl.mode == timer_pkg::MODE_CAPTURE) && edge_sel)
            |=> (s_q.cap == $past(s_q.count));
    endproperty
    a_capture: assert property (p_capture) // R13
        else $error("count not captured on selected edge");

    property p_capcmp_start;
        @(posedge pclk) disable iff (!presetn)
        (s_q.ctrl.en && (s_q.ctrl.mode == timer_pkg::MODE_CAPCMP) && !s_q.started && edge_sel
         && !wr_any) |=> s_q.started && !s_q.status[timer_pkg::ST_CAPTURE];
    endproperty
    a_capcmp_start: assert property (p_capcmp_start) // R14
        else $error("first edge did not start counting or was captured");

    property p_out_holds;
        @(posedge pclk) disable iff (!presetn)
        (s_q.ctrl.en && !tick && !wr_any) |=> $stable(timer_output_pin);
    endproperty
    a_out_holds: assert property (p_out_holds) // R16
        else $error("output moved without a tick");

    property p_presc_clear;
        @(posedge pclk) disable iff (!presetn)
        (!s_q.ctrl.en) |=> (s_q.presc == '0);
    endproperty
    a_presc_clear: assert property (p_presc_clear) // R18
        else $error("prescaler not cleared while disabled");

    property p_div_two;
        @(posedge pclk) disable iff (!presetn)
        // a write in the gap may legally stop the prescaler, so it voids the check
        (tick && (s_q.ctrl.prescale_exponent == 3'h1) && !wr_any) ##1 !wr_any |-> s_two_ticks;
    endproperty
    a_div_two: assert property (p_div_two) // R17
        else $error("divide by two spacing wrong");

    property p_count_step;
        @(posedge pclk) disable iff (!presetn)
        (tick && count_en && !hit_reload && !wr_any)
            |=> (s_q.count == timer_pkg::CNT_W'($past(s_q.count) + 16'h0001));
    endproperty
    a_count_step: assert property (p_count_step) // R19
        else $error("count did not step by one");

endmodule // timer_compare_gated_capture

//--- verification/timer_input_model.sv
// Purpose: far-side model driving the timer input pin
// Assumes: input changes right after a rising pclk edge
// Notes: output pin is watched by the bench directly
`timescale 1ns/1ps
module timer_input_model
(
    input wire logic pclk,
    output logic timer_input
);
    // ------------------------------------------------------------
    // pin driver
    // ------------------------------------------------------------
    initial
    begin
        timer_input = 1'b0;
    end

    // level moves only just after an edge, so the timer sees it next edge
    task automatic drive(input logic v);
        @(posedge pclk);
        timer_input <= v;
    endtask
endmodule // timer_input_model

//--- verification/tb_timer_compare_gated_capture.sv
// Purpose: self-checking bench for the compare/gated/capture timer
// Assumes: zero-wait APB slave, timer input synchronous to pclk
// Notes: compare timing cases run from a row table
`timescale 1ns/1ps
module tb_timer_compare_gated_capture;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic timer_input;
    logic timer_output_pin;
    logic timer_output_oe;
    logic irq;
    logic [31:0] rd;
    logic er;
    int n_errors;
    int samples_checked;
    int cyc;
    int n;
    // nx: cycles from enable to first toggle, (reload - start) times divisor
    typedef struct packed {logic [2:0] ex; logic pol; logic [15:0] st; logic [15:0] rl;
        logic [15:0] nx;} row_t;
    row_t rows [8] = '{
        '{3'h0, 1'b0, 16'h0000, 16'h0002, 16'h0002}, '{3'h1, 1'b1, 16'h0003, 16'h0007, 16'h0008},
        '{3'h2, 1'b0, 16'h000a, 16'h000d, 16'h000c}, '{3'h3, 1'b1, 16'h0000, 16'h0003, 16'h0018},
        '{3'h4, 1'b0, 16'h0001, 16'h0003, 16'h0020}, '{3'h5, 1'b1, 16'h0000, 16'h0002, 16'h0040},
        '{3'h6, 1'b0, 16'h0000, 16'h0001, 16'h0040}, '{3'h7, 1'b1, 16'h0000, 16'h0001, 16'h0080}};

    timer_compare_gated_capture DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_input(timer_input),
        .timer_output_pin(timer_output_pin), .timer_output_oe(timer_output_oe), .irq(irq));
    timer_input_model far (.pclk(pclk), .timer_input(timer_input));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic cmp_word(input logic [31:0] a, input logic [31:0] e);
        samples_checked++;
        if (a !== e)
            $display("BAD %0t word %h want %h", $time, a, e);
        if (a !== e)
            n_errors++;
    endtask

    task automatic cmp_bit(input logic a, input logic e);
        cmp_word({31'h0, a}, {31'h0, e});
    endtask

    // holds the request until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        cmp_word(rd, e);
    endtask

    function automatic logic [31:0] cw(input logic en, input timer_pkg::mode_t m,
        input logic p, input logic [2:0] ex);
        timer_pkg::ctrl_t c;
        c = '{af_en: 1'b1, prescale_exponent: ex, output_polarity_sel: p, mode: m, en: en};
        return 32'(c);
    endfunction

    // edges until the output pin changes
    task automatic wait_flip();
        logic o;
        o = timer_output_pin;
        n = 0;
        do
        begin
            @(posedge pclk);
            #1;
            n++;
        end
        while (timer_output_pin === o && n < 2000);
    endtask

    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            n_errors++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        cmp_bit(timer_output_oe, 1'b0);
        cmp_bit(irq, 1'b0);
        rdchk(timer_pkg::OFS_RELOAD, 32'h0000ffff);
        rdchk(timer_pkg::OFS_CTRL, 32'h0);
        apb(1'b0, 12'h01c, 32'h0);
        cmp_bit(er, 1'b1);
        apb(1'b1, timer_pkg::OFS_CAPTURE, 32'h00001234);
        rdchk(timer_pkg::OFS_CAPTURE, 32'h0);
        apb(1'b1, timer_pkg::OFS_MASK, 32'h0000000f);
        rdchk(timer_pkg::OFS_MASK, 32'h0000000f);
        // every prescale code; leftover prescaler state must not leak
        foreach (rows[i])
        begin
            apb(1'b1, timer_pkg::OFS_CTRL, cw(0, timer_pkg::MODE_COMPARE, rows[i].pol, rows[i].ex));
            apb(1'b1, timer_pkg::OFS_COUNT, {16'h0, rows[i].st});
            apb(1'b1, timer_pkg::OFS_RELOAD, {16'h0, rows[i].rl});
            cmp_bit(timer_output_pin, rows[i].pol);
            cmp_bit(timer_output_oe, 1'b1);
            apb(1'b1, timer_pkg::OFS_CTRL, cw(1, timer_pkg::MODE_COMPARE, rows[i].pol, rows[i].ex));
            wait_flip();
            cmp_word(32'(n), {16'h0, rows[i].nx});
            cmp_bit(timer_output_pin, ~rows[i].pol);
            cmp_bit(irq, 1'b1);
            apb(1'b1, timer_pkg::OFS_CTRL, cw(0, timer_pkg::MODE_COMPARE, rows[i].pol, rows[i].ex));
            rdchk(timer_pkg::OFS_STATUS, 32'h1);
            cmp_bit(irq, 1'b0);
            cmp_bit(timer_output_pin, rows[i].pol);
        end
        for (int p = 0; p < 2; p++)
        begin
            apb(1'b1, timer_pkg::OFS_CTRL, cw(0, timer_pkg::MODE_GATED, p[0], 3'h0));
            far.drive(p[0]);
            apb(1'b1, timer_pkg::OFS_COUNT, 32'h0000000e);
            apb(1'b1, timer_pkg::OFS_RELOAD, 32'h00000010);
            apb(1'b0, timer_pkg::OFS_STATUS, 32'h0);
            apb(1'b1, timer_pkg::OFS_CTRL, cw(1, timer_pkg::MODE_GATED, p[0], 3'h0));
            repeat (5) @(posedge pclk);
            rdchk(timer_pkg::OFS_COUNT, 32'h0000000e);
            far.drive(~p[0]);
            repeat (3) @(posedge pclk);
            far.drive(p[0]);
            repeat (2) @(posedge pclk);
            rdchk(timer_pkg::OFS_COUNT, 32'h00000003);
            rdchk(timer_pkg::OFS_STATUS, 32'h00000003);
            cmp_bit(timer_input, p[0]);
            cmp_bit(timer_output_pin, ~p[0]);
            apb(1'b1, timer_pkg::OFS_CTRL, cw(0, timer_pkg::MODE_CAPTURE, p[0], 3'h3));
            apb(1'b1, timer_pkg::OFS_COUNT, 32'h0);
            apb(1'b1, timer_pkg::OFS_RELOAD, 32'h0000ffff);
            apb(1'b0, timer_pkg::OFS_STATUS, 32'h0);
            apb(1'b1, timer_pkg::OFS_CTRL, cw(1, timer_pkg::MODE_CAPTURE, p[0], 3'h3));
            repeat (18) @(posedge pclk);
            far.drive(~p[0]);
            repeat (4) @(posedge pclk);
            rdchk(timer_pkg::OFS_CAPTURE, 32'h00000002);
            rdchk(timer_pkg::OFS_STATUS, 32'h00000004);
        end
        apb(1'b1, timer_pkg::OFS_CTRL, cw(0, timer_pkg::MODE_CAPCMP, 1'b0, 3'h0));
        far.drive(1'b0);
        apb(1'b1, timer_pkg::OFS_COUNT, 32'h0);
        apb(1'b0, timer_pkg::OFS_STATUS, 32'h0);
        apb(1'b1, timer_pkg::OFS_CTRL, cw(1, timer_pkg::MODE_CAPCMP, 1'b0, 3'h0));
        repeat (20) @(posedge pclk);
        rdchk(timer_pkg::OFS_COUNT, 32'h0);
        far.drive(1'b1);
        rdchk(timer_pkg::OFS_STATUS, 32'h0);
        far.drive(1'b0);
        repeat (10) @(posedge pclk);
        far.drive(1'b1);
        repeat (2) @(posedge pclk);
        rdchk(timer_pkg::OFS_STATUS, 32'h00000004);
        apb(1'b1, timer_pkg::OFS_CTRL, cw(0, timer_pkg::MODE_PWM, 1'b1, 3'h0));
        apb(1'b1, timer_pkg::OFS_COUNT, 32'h0);
        apb(1'b1, timer_pkg::OFS_PWM, 32'h00000040);
        apb(1'b1, timer_pkg::OFS_RELOAD, 32'h00000080);
        cmp_bit(timer_output_pin, 1'b1);
        apb(1'b1, timer_pkg::OFS_CTRL, cw(1, timer_pkg::MODE_PWM, 1'b1, 3'h0));
        wait_flip();
        cmp_word(32'(n), 32'h40);
        wait_flip();
        cmp_word(32'(n), 32'h40);
        cmp_bit(timer_output_pin, 1'b1);
        apb(1'b1, timer_pkg::OFS_CTRL, cw(1, timer_pkg::MODE_PWM, 1'b0, 3'h0));
        repeat (3) @(posedge pclk);
        #1;
        cmp_bit(timer_output_pin, 1'b1);
        // reset in mid-run must bring the output pin, output enable, RELOAD and CTRL back to their reset values
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        cmp_bit(timer_output_pin, 1'b0);
        cmp_bit(timer_output_oe, 1'b0);
        rdchk(timer_pkg::OFS_RELOAD, 32'h0000ffff);
        rdchk(timer_pkg::OFS_CTRL, 32'h0);
        wrap_up();
    end
endmodule // tb_timer_compare_gated_capture
